/* include/emb_defines.svh */
/*
 * Register offsets, field positions, reset values and timing counts of
 * the external memory bus block. Assumes a 32-bit APB slave at byte
 * addresses and a 200 MHz pclk.
 */
// How it works
// - byte select table write drives the latch byte on both bus halves
// - byte select mode strobes the high write line, low line unused
// - byte select picks byte by pointer bit 0 on byte line or selects
// - 8-bit width runs multiplexed, data on the low eight lines
// - 8-bit fetch takes two bytes in one cycle, half each
// - latch strobe marks sixteen address bits valid on the bus
// - read enable takes one byte, byte line toggles, second byte read
// - chip enable low on every access, high during sleep
// - 8-bit table write sets byte line to pointer bit 0
// - slower run clock stretches bus cycles, bus keeps working
// - sleep or idle stops the bus and freezes the pins
// - in sleep only chip enable and byte selects change, to high
// - bus control register absent on small pin-count variants
// - bus disable returns pins to port use when running internally, except in microprocessor mode
// - wait field adds zero to three cycles after table operations
// - write mode bits pick byte write, word write or byte select
`ifndef EMB_DEFINES_SVH
`define EMB_DEFINES_SVH

`define EMB_OFF_CTRL 12'h000
`define EMB_OFF_CFG 12'h004
`define EMB_OFF_PTR 12'h008
`define EMB_OFF_LATCH 12'h00c
`define EMB_OFF_CMD 12'h010
`define EMB_OFF_RDATA 12'h014

`define EMB_CTRL_DIS 7
`define EMB_CTRL_WAIT 5:4
`define EMB_CTRL_WM 1:0
`define EMB_CTRL_RST 8'h30
`define EMB_CTRL_MASK 8'hb3

`define EMB_CFG_WAITEN 7
`define EMB_CFG_WIDTH 6
`define EMB_CFG_ABW 5:4
`define EMB_CFG_PM 1:0
`define EMB_CFG_RST 8'hc0
`define EMB_CFG_MASK 8'hf3

`define EMB_WM_BYTE_WR 2'h0
`define EMB_WM_WORD_WR 2'h1
`define EMB_WM_BYTE_SEL 2'h2
`define EMB_PM_MICROCTRL 2'h3
`define EMB_PM_MICROPROC 2'h0

`define EMB_OP_FETCH 2'h1
`define EMB_OP_TABLE_RD 2'h2
`define EMB_OP_TABLE_WR 2'h3

`define EMB_TCY_NS 20
`define EMB_CLK_NS 5
`define EMB_TCY_CLKS (`EMB_TCY_NS / `EMB_CLK_NS)

`endif

/* include/emb_pkg.sv */
/*
 * Types of the external memory bus block.
 * Assumes emb_defines.svh for all numeric constants.
 */
package emb_pkg;
	typedef enum logic [2:0] {
		EMB_IDLE = 3'h0,
		EMB_ADDR = 3'h1,
		EMB_RD_LO = 3'h2,
		EMB_RD_HI = 3'h3,
		EMB_WR = 3'h4,
		EMB_WAITST = 3'h5
	} emb_state_t;
endpackage : emb_pkg

/* src/emb_bus.sv */
/*
 * External memory bus master with byte select and 8-bit multiplexed
 * modes, software driven over APB. Assumes pins are resolved outside
 * (output enables active low) and that sleep and slow-run inputs are
 * synchronous to pclk.
 */
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "emb_defines.svh"

module emb_bus
	import emb_pkg::*;
#(
	parameter int TCY_CLKS = `EMB_TCY_CLKS,
	parameter bit HAS_BUS_CTRL = 1'b1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sleep_idle,
	input wire logic exec_internal,
	input wire logic [3:0] run_div,
	input wire logic [15:0] ad_i,
	output logic [15:0] ad_o,
	output logic ad_oe_n,
	output logic [3:0] addr_hi_o,
	output logic ale,
	output logic oe_n,
	output logic high_write_strobe_n,
	output logic low_write_strobe_n,
	output logic chip_enable_n,
	output logic upper_byte_select_n,
	output logic lower_byte_select_n,
	output logic byte_address_line,
	output logic pins_as_io
);

	if (TCY_CLKS < 2 || TCY_CLKS % 2 != 0 || TCY_CLKS > 32) begin : g_tcy
		$error("emb_bus: TCY_CLKS must be even, 2..32");
	end

	localparam logic [4:0] HALF_LAST = 5'(TCY_CLKS / 2 - 1);

	logic [7:0] ctrl_ff;
	logic [7:0] cfg_ff;
	logic [20:0] table_pointer_ff;
	logic [7:0] table_latch_byte_ff;
	logic [7:0] hold_latch_ff;
	logic [15:0] rdata_ff;
	logic [1:0] op_ff;
	emb_state_t state_ff;
	emb_state_t nxt_state;
	logic [3:0] div_ff;
	logic [4:0] half_ff;
	logic [2:0] wait_ff;
	logic tick;
	logic phase_end;
	logic wr_en;
	logic rd_en;
	logic start;
	logic [1:0] wm;
	logic bw16;
	logic ptr0;
	logic [7:0] ctrl_view;

	function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
		hit = (a == o);
	endfunction : hit

	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && penable && !pwrite;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !(hit(paddr, `EMB_OFF_CTRL)
		|| hit(paddr, `EMB_OFF_CFG) || hit(paddr, `EMB_OFF_PTR)
		|| hit(paddr, `EMB_OFF_LATCH) || hit(paddr, `EMB_OFF_CMD)
		|| hit(paddr, `EMB_OFF_RDATA));

	// small-package variant: register absent, reads zero, fixed reset value
	assign ctrl_view = HAS_BUS_CTRL ? ctrl_ff : 8'h00;
	assign wm = ctrl_ff[`EMB_CTRL_WM];
	assign bw16 = cfg_ff[`EMB_CFG_WIDTH];
	assign ptr0 = table_pointer_ff[0];

	// a bus in microcontroller mode never runs; busy commands are dropped
	assign start = wr_en && hit(paddr, `EMB_OFF_CMD) && state_ff == EMB_IDLE
		&& pwdata[1:0] != 2'h0
		&& cfg_ff[`EMB_CFG_PM] != `EMB_PM_MICROCTRL;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff <= `EMB_CTRL_RST;
		end else if (HAS_BUS_CTRL && wr_en && hit(paddr, `EMB_OFF_CTRL)
			&& cfg_ff[`EMB_CFG_PM] != `EMB_PM_MICROCTRL) begin
			ctrl_ff <= pwdata[7:0] & `EMB_CTRL_MASK;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_ff <= `EMB_CFG_RST;
		end else if (wr_en && hit(paddr, `EMB_OFF_CFG)) begin
			cfg_ff <= pwdata[7:0] & `EMB_CFG_MASK;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			table_pointer_ff <= 21'h000000;
		end else if (wr_en && hit(paddr, `EMB_OFF_PTR)) begin
			table_pointer_ff <= pwdata[20:0];
		end
	end

	// a table read landing in the same cycle as a software write wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			table_latch_byte_ff <= 8'h00;
		end else if (!sleep_idle && tick && phase_end
			&& state_ff == EMB_RD_LO && op_ff == `EMB_OP_TABLE_RD) begin
			table_latch_byte_ff <= (bw16 && ptr0) ? ad_i[15:8] : ad_i[7:0];
		end else if (wr_en && hit(paddr, `EMB_OFF_LATCH)) begin
			table_latch_byte_ff <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_ff <= 2'h0;
		end else if (start) begin
			op_ff <= pwdata[1:0];
		end
	end

	// even word-write address parks the byte for the odd partner
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_latch_ff <= 8'h00;
		end else if (start && pwdata[1:0] == `EMB_OP_TABLE_WR && bw16
			&& wm == `EMB_WM_WORD_WR && !ptr0) begin
			hold_latch_ff <= table_latch_byte_ff;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_ff <= 16'h0000;
		end else if (!sleep_idle && tick && phase_end) begin
			if (state_ff == EMB_RD_LO)
				rdata_ff <= bw16 ? ad_i : {rdata_ff[15:8], ad_i[7:0]};
			else if (state_ff == EMB_RD_HI)
				rdata_ff <= {ad_i[7:0], rdata_ff[7:0]};
		end
	end

	// slower run clocks stretch every phase by the divider ratio
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_ff <= 4'h0;
		end else if (start) begin
			// phases start whole, whatever the divider was doing
			div_ff <= 4'h0;
		end else if (!sleep_idle) begin
			div_ff <= (div_ff >= run_div) ? 4'h0 : div_ff + 4'h1;
		end
	end
	assign tick = (div_ff >= run_div);
	assign phase_end = (half_ff == HALF_LAST);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			half_ff <= 5'h00;
		end else if (start) begin
			half_ff <= 5'h00;
		end else if (!sleep_idle && tick) begin
			half_ff <= phase_end ? 5'h00 : half_ff + 5'h01;
		end
	end

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			EMB_IDLE: begin
				if (start)
					nxt_state = EMB_ADDR;
			end
			EMB_ADDR: begin
				nxt_state = (op_ff == `EMB_OP_TABLE_WR) ? EMB_WR : EMB_RD_LO;
			end
			EMB_RD_LO: begin
				if (op_ff == `EMB_OP_FETCH && !bw16)
					nxt_state = EMB_RD_HI;
				else if (op_ff != `EMB_OP_FETCH
					&& cfg_ff[`EMB_CFG_WAITEN] && ctrl_ff[`EMB_CTRL_WAIT] != 2'h0)
					nxt_state = EMB_WAITST;
				else
					nxt_state = EMB_IDLE;
			end
			EMB_RD_HI: begin
				nxt_state = EMB_IDLE;
			end
			EMB_WR: begin
				if (cfg_ff[`EMB_CFG_WAITEN] && ctrl_ff[`EMB_CTRL_WAIT] != 2'h0)
					nxt_state = EMB_WAITST;
				else
					nxt_state = EMB_IDLE;
			end
			EMB_WAITST: begin
				if (wait_ff == 3'h1)
					nxt_state = EMB_IDLE;
			end
			default: nxt_state = EMB_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= EMB_IDLE;
		end else if (start) begin
			state_ff <= EMB_ADDR;
		end else if (!sleep_idle && tick && phase_end) begin
			state_ff <= nxt_state;
		end
	end

	// wait counts whole cycles, two half phases each
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_ff <= 3'h0;
		end else if (!sleep_idle && tick && phase_end) begin
			if (state_ff != EMB_WAITST)
				wait_ff <= {ctrl_ff[`EMB_CTRL_WAIT], 1'b0};
			else
				wait_ff <= wait_ff - 3'h1;
		end
	end

	// pins are re-decoded every clock outside sleep so wake-up restores them at once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ad_o <= 16'h0000;
			ad_oe_n <= 1'b1;
			addr_hi_o <= 4'h0;
			ale <= 1'b0;
			oe_n <= 1'b1;
			high_write_strobe_n <= 1'b1;
			low_write_strobe_n <= 1'b1;
			chip_enable_n <= 1'b1;
			upper_byte_select_n <= 1'b1;
			lower_byte_select_n <= 1'b1;
			byte_address_line <= 1'b0;
		end else if (sleep_idle) begin
			chip_enable_n <= 1'b1;
			upper_byte_select_n <= 1'b1;
			lower_byte_select_n <= 1'b1;
		end else begin
			ale <= 1'b0;
			oe_n <= 1'b1;
			high_write_strobe_n <= 1'b1;
			low_write_strobe_n <= 1'b1;
			chip_enable_n <= (state_ff == EMB_IDLE);
			upper_byte_select_n <= (state_ff == EMB_IDLE);
			lower_byte_select_n <= (state_ff == EMB_IDLE);
			unique case (state_ff)
				EMB_IDLE: begin
					ad_oe_n <= 1'b1;
					byte_address_line <= 1'b0;
				end
				EMB_ADDR: begin
					ale <= 1'b1;
					ad_oe_n <= 1'b0;
					addr_hi_o <= table_pointer_ff[20:17];
					ad_o <= (op_ff == `EMB_OP_FETCH)
						? {table_pointer_ff[16:2], 1'b0}
						: table_pointer_ff[16:1];
					byte_address_line <= (op_ff == `EMB_OP_FETCH) ? 1'b0 : ptr0;
				end
				EMB_RD_LO: begin
					ad_oe_n <= 1'b1;
					if (!bw16)
						ad_o <= {table_pointer_ff[16:9], 8'h00};
					oe_n <= 1'b0;
					byte_address_line <= (op_ff == `EMB_OP_FETCH) ? 1'b0 : ptr0;
				end
				EMB_RD_HI: begin
					ad_oe_n <= 1'b1;
					oe_n <= 1'b0;
					byte_address_line <= 1'b1;
				end
				EMB_WR: begin
					ad_oe_n <= 1'b0;
					byte_address_line <= ptr0;
					if (!bw16) begin
						ad_o <= {table_pointer_ff[16:9], table_latch_byte_ff};
						low_write_strobe_n <= 1'b0;
					end else if (wm == `EMB_WM_BYTE_SEL) begin
						ad_o <= {table_latch_byte_ff, table_latch_byte_ff};
						high_write_strobe_n <= 1'b0;
						upper_byte_select_n <= !ptr0;
						lower_byte_select_n <= ptr0;
					end else if (wm == `EMB_WM_WORD_WR) begin
						ad_oe_n <= !ptr0;
						ad_o <= {table_latch_byte_ff, hold_latch_ff};
						high_write_strobe_n <= !ptr0;
					end else begin
						ad_o <= {table_latch_byte_ff, table_latch_byte_ff};
						high_write_strobe_n <= !ptr0;
						low_write_strobe_n <= ptr0;
					end
				end
				EMB_WAITST: begin
					ad_oe_n <= 1'b1;
				end
				default: ad_oe_n <= 1'b1;
			endcase
		end
	end

	// port function always in microcontroller mode, never in microprocessor mode, otherwise only while idle, running internally and disabled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pins_as_io <= 1'b0;
		end else begin
			pins_as_io <= cfg_ff[`EMB_CFG_PM] == `EMB_PM_MICROCTRL
				|| (cfg_ff[`EMB_CFG_PM] != `EMB_PM_MICROPROC
				&& ctrl_view[`EMB_CTRL_DIS] && exec_internal
				&& state_ff == EMB_IDLE);
		end
	end

	always_comb begin
		prdata = 32'h00000000;
		if (rd_en) begin
			if (hit(paddr, `EMB_OFF_CTRL))
				prdata = {24'h000000, ctrl_view};
			else if (hit(paddr, `EMB_OFF_CFG))
				prdata = {24'h000000, cfg_ff};
			else if (hit(paddr, `EMB_OFF_PTR))
				prdata = {11'h000, table_pointer_ff};
			else if (hit(paddr, `EMB_OFF_LATCH))
				prdata = {24'h000000, table_latch_byte_ff};
			else if (hit(paddr, `EMB_OFF_CMD))
				prdata = {30'h00000000, pins_as_io, state_ff != EMB_IDLE};
			else if (hit(paddr, `EMB_OFF_RDATA))
				prdata = {16'h0000, rdata_ff};
		end
	end

endmodule : emb_bus
`default_nettype wire

/* tb/emb_bus_sva.sv */
/* pin checker for emb_bus; mirrors mode bits from apb writes.
   assumes no control writes in microcontroller mode */
`timescale 1ns/1ps
`default_nettype none
`include "emb_defines.svh"
module emb_bus_sva #(
	parameter int TCY_CLKS = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic sleep_idle,
	input wire logic [3:0] run_div,
	input wire logic [15:0] ad_o,
	input wire logic ad_oe_n,
	input wire logic ale,
	input wire logic oe_n,
	input wire logic high_write_strobe_n,
	input wire logic low_write_strobe_n,
	input wire logic chip_enable_n,
	input wire logic upper_byte_select_n,
	input wire logic lower_byte_select_n,
	input wire logic byte_address_line
);
	logic [1:0] wm_ff;
	logic [1:0] op_ff;
	logic wide16_ff;
	logic p0_ff;
	logic slp_ff;
	logic [7:0] ale_cnt_ff;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wm_ff <= 2'h0;
			op_ff <= 2'h0;
			wide16_ff <= 1'b1;
			p0_ff <= 1'b0;
		end else if (psel && penable && pwrite) begin
			case (paddr)
			`EMB_OFF_CTRL: wm_ff <= pwdata[1:0];
			`EMB_OFF_CFG: wide16_ff <= pwdata[`EMB_CFG_WIDTH];
			`EMB_OFF_PTR: p0_ff <= pwdata[0];
			`EMB_OFF_CMD: op_ff <= pwdata[1:0];
			default: ;
			endcase
		end
	end
	// a sleep inside the latch pulse stretches it legally
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ale_cnt_ff <= 8'h00;
			slp_ff <= 1'b0;
		end else begin
			ale_cnt_ff <= ale ? ale_cnt_ff + 8'h01 : 8'h00;
			slp_ff <= ale && (slp_ff || sleep_idle);
		end
	end
	property p_ce_acc;
		(!oe_n || !high_write_strobe_n || !low_write_strobe_n) && !sleep_idle
			&& !$past(sleep_idle) |-> !chip_enable_n;
	endproperty
	a_ce_acc: assert property (p_ce_acc) else $error("ce idle in access");
	property p_slp_hi;
		sleep_idle |=> chip_enable_n && upper_byte_select_n
			&& lower_byte_select_n;
	endproperty
	a_slp_hi: assert property (p_slp_hi) else $error("sleep pins low");
	property p_slp_hold;
		sleep_idle ##1 sleep_idle |=> $stable(ad_o) && $stable(oe_n)
			&& $stable(ale) && $stable(byte_address_line);
	endproperty
	a_slp_hold: assert property (p_slp_hold) else $error("pins moved");
	property p_bs_wrl;
		wm_ff[1] && wide16_ff |-> low_write_strobe_n;
	endproperty
	a_bs_wrl: assert property (p_bs_wrl) else $error("low strobe used");
	property p_bs_dup;
		wm_ff[1] && wide16_ff && !high_write_strobe_n
			|-> ad_o[15:8] == ad_o[7:0] && !ad_oe_n;
	endproperty
	a_bs_dup: assert property (p_bs_dup) else $error("halves differ");
	property p_bs_sel;
		wm_ff[1] && wide16_ff && !high_write_strobe_n |->
			upper_byte_select_n == !p0_ff && lower_byte_select_n == p0_ff;
	endproperty
	a_bs_sel: assert property (p_bs_sel) else $error("bad byte select");
	property p_ale_len;
		$fell(ale) && !slp_ff
			|-> ale_cnt_ff == 8'((TCY_CLKS / 2) * (run_div + 1));
	endproperty
	a_ale_len: assert property (p_ale_len) else $error("ale length");
	property p_ale_addr;
		ale |-> !ad_oe_n && oe_n;
	endproperty
	a_ale_addr: assert property (p_ale_addr) else $error("ale no addr");
	property p_f8_ord;
		!wide16_ff && op_ff == `EMB_OP_FETCH && run_div == 4'h0
			&& $fell(oe_n)
			|-> !byte_address_line ##2 byte_address_line && !oe_n;
	endproperty
	a_f8_ord: assert property (p_f8_ord) else $error("byte order");
	property p_w8_ba;
		!wide16_ff && !low_write_strobe_n |-> byte_address_line == p0_ff;
	endproperty
	a_w8_ba: assert property (p_w8_ba) else $error("byte line");
	c_wr: cover property ($fell(high_write_strobe_n));
	c_f8: cover property ($fell(oe_n) && !wide16_ff);
	c_slp: cover property (sleep_idle ##1 sleep_idle);
endmodule : emb_bus_sva
bind emb_bus emb_bus_sva #(.TCY_CLKS(TCY_CLKS)) u_sva (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.sleep_idle(sleep_idle), .run_div(run_div), .ad_o(ad_o),
	.ad_oe_n(ad_oe_n), .ale(ale), .oe_n(oe_n),
	.high_write_strobe_n(high_write_strobe_n),
	.low_write_strobe_n(low_write_strobe_n),
	.chip_enable_n(chip_enable_n),
	.upper_byte_select_n(upper_byte_select_n),
	.lower_byte_select_n(lower_byte_select_n),
	.byte_address_line(byte_address_line)
);
`default_nettype wire

/* tb/emb_mem_model.sv */
/* word memory on the multiplexed bus, address latched on ale.
   assumes wide tells it whether the bus runs 16 or 8 bits */
`timescale 1ns/1ps
`default_nettype none
module emb_mem_model (
	input wire logic pclk,
	input wire logic wide,
	input wire logic [15:0] ad_o,
	input wire logic ad_oe_n,
	input wire logic ale,
	input wire logic oe_n,
	input wire logic chip_enable_n,
	input wire logic high_write_strobe_n,
	input wire logic low_write_strobe_n,
	input wire logic upper_byte_select_n,
	input wire logic lower_byte_select_n,
	input wire logic byte_address_line,
	output logic [15:0] ad_i
);
	logic [15:0] mem [0:255];
	logic [15:0] last = 16'h5a5a;
	logic [15:0] w;
	logic [7:0] adr;
	logic en;
	logic wr;
	assign w = mem[adr];
	assign en = !chip_enable_n && !oe_n;
	assign wr = !chip_enable_n && !ad_oe_n;
	// released bus shows the inverse of its last value, never a copy
	assign ad_i = !en ? ~last : wide ? w
		: {~last[15:8], byte_address_line ? w[15:8] : w[7:0]};
	always @(posedge pclk) begin
		if (en)
			last <= ad_i;
		if (ale)
			adr <= ad_o[7:0];
		if (wr && !high_write_strobe_n && !upper_byte_select_n)
			mem[adr][15:8] <= ad_o[15:8];
		if (wr && !high_write_strobe_n && !lower_byte_select_n)
			mem[adr][7:0] <= ad_o[7:0];
		if (wr && !low_write_strobe_n && !wide && byte_address_line)
			mem[adr][15:8] <= ad_o[7:0];
		if (wr && !low_write_strobe_n && !wide && !byte_address_line)
			mem[adr][7:0] <= ad_o[7:0];
	end
endmodule : emb_mem_model
`default_nettype wire

/* tb/external_memory_bus_byte_modes_tb.sv */
/* bench: apb master drives emb_bus facing a memory model.
   assumes the default four clocks per instruction cycle */
`timescale 1ns/1ps
`default_nettype none
`include "emb_defines.svh"
module external_memory_bus_byte_modes_tb;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic sleep_idle = 1'b0;
	logic exec_internal = 1'b0;
	logic wide = 1'b1;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] run_div = 4'h0;
	logic [31:0] prdata, rd;
	logic [15:0] ad_i, ad_o;
	logic [3:0] addr_hi_o;
	logic pready, pslverr, err, ad_oe_n, ale, oe_n, high_write_strobe_n;
	logic low_write_strobe_n, chip_enable_n, upper_byte_select_n;
	logic lower_byte_select_n, byte_address_line, pins_as_io;
	int errors = 0;
	int tests_run = 0;
	int cyc = 0;
	int oe_cnt = 0;
	int t0, dur, d0;
	emb_bus u_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sleep_idle(sleep_idle),
		.exec_internal(exec_internal), .run_div(run_div), .ad_i(ad_i),
		.ad_o(ad_o), .ad_oe_n(ad_oe_n), .addr_hi_o(addr_hi_o), .ale(ale),
		.oe_n(oe_n), .high_write_strobe_n(high_write_strobe_n),
		.low_write_strobe_n(low_write_strobe_n),
		.chip_enable_n(chip_enable_n),
		.upper_byte_select_n(upper_byte_select_n),
		.lower_byte_select_n(lower_byte_select_n),
		.byte_address_line(byte_address_line), .pins_as_io(pins_as_io)
	);
	emb_mem_model u_mem (
		.pclk(pclk), .wide(wide), .ad_o(ad_o), .ad_oe_n(ad_oe_n),
		.ale(ale), .oe_n(oe_n), .chip_enable_n(chip_enable_n),
		.high_write_strobe_n(high_write_strobe_n),
		.low_write_strobe_n(low_write_strobe_n),
		.upper_byte_select_n(upper_byte_select_n),
		.lower_byte_select_n(lower_byte_select_n),
		.byte_address_line(byte_address_line), .ad_i(ad_i)
	);
	always #2.5 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (!oe_n)
			oe_cnt <= oe_cnt + 1;
	end
	task automatic complete_run;
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : complete_run
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic op(input logic [1:0] c, input logic slp);
		apb(1'b1, `EMB_OFF_CMD, {30'h0, c});
		t0 = cyc;
		if (slp) begin
			sleep_idle <= 1'b1;
			repeat (20) @(posedge pclk);
			chk({29'h0, chip_enable_n, upper_byte_select_n,
				lower_byte_select_n}, 32'h7);
			sleep_idle <= 1'b0;
		end
		do apb(1'b0, `EMB_OFF_CMD, 32'h0);
		while (rd[0] !== 1'b0 && cyc - t0 < 2000);
		if (rd[0] !== 1'b0) begin
			errors++;
			$display("Error %0t: bus operation never finished", $time);
			complete_run();
		end
		dur = cyc - t0;
	endtask : op
	task automatic fetch(input logic [31:0] exp, input int n_oe);
		int o0;
		apb(1'b1, `EMB_OFF_PTR, 32'h4);
		o0 = oe_cnt;
		op(`EMB_OP_FETCH, 1'b0);
		apb(1'b0, `EMB_OFF_RDATA, 32'h0);
		chk(rd, exp);
		chk(32'(oe_cnt - o0), 32'(n_oe));
	endtask : fetch
	initial begin
		repeat (20000) @(posedge pclk);
		errors++;
		complete_run();
	end
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `EMB_OFF_CTRL, 32'h0);
		chk(rd, 32'h30);
		apb(1'b0, `EMB_OFF_CFG, 32'h0);
		chk(rd, 32'hc0);
		apb(1'b0, 12'h0f0, 32'h0);
		chk({31'h0, err}, 32'h1);
		apb(1'b1, `EMB_OFF_CTRL, {30'h0, `EMB_WM_BYTE_SEL});
		for (int i = 0; i < 2; i++) begin
			apb(1'b1, `EMB_OFF_PTR, 32'h4 + i);
			apb(1'b1, `EMB_OFF_LATCH, i ? 32'h3c : 32'ha5);
			op(`EMB_OP_TABLE_WR, 1'b0);
		end
		for (int i = 0; i < 2; i++) begin
			apb(1'b1, `EMB_OFF_PTR, 32'h4 + i);
			op(`EMB_OP_TABLE_RD, 1'b0);
			apb(1'b0, `EMB_OFF_LATCH, 32'h0);
			chk(rd, i ? 32'h3c : 32'ha5);
		end
		fetch(32'h3ca5, 2);
		// waits stay off before the clock is slowed
		run_div <= 4'h3;
		fetch(32'h3ca5, 8);
		run_div <= 4'h0;
		op(`EMB_OP_FETCH, 1'b1);
		apb(1'b0, `EMB_OFF_RDATA, 32'h0);
		chk(rd, 32'h3ca5);
		apb(1'b1, `EMB_OFF_CFG, 32'h80);
		wide <= 1'b0;
		fetch(32'h3ca5, 4);
		apb(1'b1, `EMB_OFF_PTR, 32'h5);
		apb(1'b1, `EMB_OFF_LATCH, 32'h77);
		op(`EMB_OP_TABLE_WR, 1'b0);
		fetch(32'h77a5, 4);
		apb(1'b1, `EMB_OFF_CFG, 32'hc0);
		wide <= 1'b1;
		op(`EMB_OP_TABLE_RD, 1'b0);
		d0 = dur;
		apb(1'b1, `EMB_OFF_CTRL, 32'h32);
		op(`EMB_OP_TABLE_RD, 1'b0);
		chk(32'(dur - d0), 32'(3 * `EMB_TCY_CLKS));
		apb(1'b1, `EMB_OFF_CFG, 32'hc1);
		exec_internal <= 1'b1;
		apb(1'b1, `EMB_OFF_CTRL, 32'h82);
		repeat (4) @(posedge pclk);
		chk({31'h0, pins_as_io}, 32'h1);
		apb(1'b1, `EMB_OFF_CTRL, 32'h02);
		repeat (4) @(posedge pclk);
		chk({31'h0, pins_as_io}, 32'h0);
		apb(1'b1, `EMB_OFF_PTR, 32'h1e0004);
		op(`EMB_OP_TABLE_RD, 1'b0);
		chk({28'h0, addr_hi_o}, 32'hf);
		apb(1'b1, `EMB_OFF_CFG, 32'hc3);
		apb(1'b0, `EMB_OFF_CMD, 32'h0);
		chk(rd, 32'h2);
		complete_run();
	end
endmodule : external_memory_bus_byte_modes_tb
`default_nettype wire
